// ### src/uco_params.svh
// constants for the cell output port
`ifndef UCO_PARAMS_SVH
`define UCO_PARAMS_SVH
`define UCO_BYTE_W       8
`define UCO_BYTE_RST     8'h00
`define UCO_ROLE_ATM     1'b0
`define UCO_LINK_MAX_MHZ 33
`define UCO_SYS_MHZ      100
`define UCO_LINK_MIN_CYC (`UCO_SYS_MHZ / `UCO_LINK_MAX_MHZ)
// sampled pin vector: bit positions and idle levels
`define UCO_PIN_N        5
`define UCO_PIN_CLK      0
`define UCO_PIN_ROLE     1
`define UCO_PIN_EN       2
`define UCO_PIN_FULL     3
`define UCO_PIN_SEL      4
`define UCO_PIN_IDLE     5'h1C
`endif

// ### src/uco_pkg.sv
// types for the cell output port
package uco_pkg;
  typedef enum logic [1:0] {
    UCO_IDLE = 2'h1,
    UCO_SEL  = 2'h2
  } uco_sel_t;
  typedef logic [7:0] uco_byte_t;
endpackage : uco_pkg

// ### src/uco_cell_out.sv
// byte-wide cell output port with atm or phy layer role
`timescale 1ns/1ns
`include "uco_params.svh"

module uco_cell_out (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               layer_role_strap,
  input  wire logic               multi_phy_arrangement,
  input  wire logic               cell_out_clock,
  input  wire logic               far_read_enable_n,
  input  wire logic               far_full_n,
  input  wire logic               read_select_n,
  input  wire logic               in_valid,
  input  wire uco_pkg::uco_byte_t in_byte,
  input  wire logic               in_first,
  output logic                    in_ready,
  output uco_pkg::uco_byte_t      cell_byte_out,
  output logic                    cell_byte_oe_n,
  output logic                    cell_start_out,
  output logic                    cell_start_oe_n
);
  import uco_pkg::*;

  // pin sampling: three stages, change taken when stages two and three agree
  logic [`UCO_PIN_N-1:0] pin_s1_r;
  logic [`UCO_PIN_N-1:0] pin_s2_r;
  logic [`UCO_PIN_N-1:0] pin_s3_r;
  logic [`UCO_PIN_N-1:0] pin_r;
  logic [`UCO_PIN_N-1:0] pin_nxt;
  logic [`UCO_PIN_N-1:0] pin_raw;

  assign pin_raw = {read_select_n, far_full_n, far_read_enable_n,
                    layer_role_strap, cell_out_clock};

  always_comb begin
    for (int i = 0; i < `UCO_PIN_N; i++) begin
      pin_nxt[i] = (pin_s2_r[i] == pin_s3_r[i]) ? pin_s3_r[i] : pin_r[i];
    end
    if (rst) begin
      pin_nxt = `UCO_PIN_IDLE;
      // strap is followed through reset so the reset drive matches the role
      pin_nxt[`UCO_PIN_ROLE] = pin_s3_r[`UCO_PIN_ROLE];
    end
  end

  always_ff @(posedge sys_clk) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
    pin_r    <= pin_nxt;
  end

  logic role_phy;
  logic en_low;
  logic full_low;
  logic sel_low;
  assign role_phy = (pin_r[`UCO_PIN_ROLE] != `UCO_ROLE_ATM);
  assign en_low   = !pin_r[`UCO_PIN_EN];
  assign full_low = !pin_r[`UCO_PIN_FULL];
  assign sel_low  = !pin_r[`UCO_PIN_SEL];

  // control and data state
  logic      clk_prev_r;
  logic      clk_prev_nxt;
  logic      en_prev_low_r;
  logic      en_prev_low_nxt;
  uco_sel_t  sel_r;
  uco_sel_t  sel_nxt;
  logic      stage_vld_r;
  logic      stage_vld_nxt;
  uco_byte_t stage_byte_r;
  uco_byte_t stage_byte_nxt;
  logic      stage_first_r;
  logic      stage_first_nxt;
  logic      ready_r;
  logic      ready_nxt;
  uco_byte_t byte_r;
  uco_byte_t byte_nxt;
  logic      soc_r;
  logic      soc_nxt;
  logic      oe_n_r;
  logic      oe_n_nxt;
  logic      link_rise;
  logic      drive;
  logic      advance;

  always_comb begin
    clk_prev_nxt    = pin_r[`UCO_PIN_CLK];
    link_rise       = pin_r[`UCO_PIN_CLK] && !clk_prev_r;
    en_prev_low_nxt = en_prev_low_r;
    sel_nxt         = sel_r;
    if (link_rise) begin
      en_prev_low_nxt = en_low;
      case (sel_r)
        UCO_IDLE: begin
          if (en_low && !en_prev_low_r && sel_low) begin
            sel_nxt = UCO_SEL;
          end
        end
        UCO_SEL: begin
          if (!en_low || !en_prev_low_r) begin
            sel_nxt = (en_low && sel_low) ? UCO_SEL : UCO_IDLE;
          end
        end
        default: sel_nxt = UCO_IDLE;
      endcase
    end
    // phy role: drive for the link cycle after read enable was seen low, and in multi phy arrangement only while selected
    if (multi_phy_arrangement) begin
      drive = en_low && (sel_nxt == UCO_SEL);
    end else begin
      drive = en_low;
    end
    if (role_phy) begin
      advance = link_rise && drive && stage_vld_r;
    end else begin
      advance = link_rise && !full_low && stage_vld_r;
    end

    stage_vld_nxt   = stage_vld_r && !advance;
    stage_byte_nxt  = stage_byte_r;
    stage_first_nxt = stage_first_r;
    if (in_valid && ready_r) begin
      stage_vld_nxt   = 1'b1;
      stage_byte_nxt  = in_byte;
      stage_first_nxt = in_first;
    end
    ready_nxt = !stage_vld_nxt;

    byte_nxt = byte_r;
    soc_nxt  = soc_r;
    oe_n_nxt = oe_n_r;
    if (link_rise) begin
      soc_nxt = advance && stage_first_r;
      if (advance) begin
        byte_nxt = stage_byte_r;
      end
      oe_n_nxt = role_phy && !drive;
    end
    if (!role_phy) begin
      oe_n_nxt = 1'b0;
    end

    if (rst) begin
      clk_prev_nxt    = 1'b0;
      en_prev_low_nxt = 1'b0;
      sel_nxt         = UCO_IDLE;
      stage_vld_nxt   = 1'b0;
      stage_byte_nxt  = `UCO_BYTE_RST;
      stage_first_nxt = 1'b0;
      ready_nxt       = 1'b0;
      byte_nxt        = `UCO_BYTE_RST;
      soc_nxt         = 1'b0;
      oe_n_nxt        = role_phy;
    end
  end

  always_ff @(posedge sys_clk) begin
    clk_prev_r    <= clk_prev_nxt;
    en_prev_low_r <= en_prev_low_nxt;
    sel_r         <= sel_nxt;
    stage_vld_r   <= stage_vld_nxt;
    stage_byte_r  <= stage_byte_nxt;
    stage_first_r <= stage_first_nxt;
    ready_r       <= ready_nxt;
    byte_r        <= byte_nxt;
    soc_r         <= soc_nxt;
    oe_n_r        <= oe_n_nxt;
  end

  assign in_ready        = ready_r;
  assign cell_byte_out   = byte_r;
  assign cell_start_out  = soc_r;
  assign cell_byte_oe_n  = oe_n_r;
  assign cell_start_oe_n = oe_n_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  atm_drives_a: assert property (
    (!role_phy && !$past(role_phy)) |-> !cell_byte_oe_n && !cell_start_oe_n)
    else $error("atm role left outputs undriven");

  soc_first_a: assert property (
    advance |=> (cell_start_out == $past(stage_first_r)) && !link_rise ##1
      $stable(cell_start_out) [*2])
    else $error("start of cell not aligned with first byte");

  single_phy_arrangement_drive_a: assert property (
    (role_phy && !multi_phy_arrangement && $rose(cell_byte_oe_n == 1'b0))
      |-> $past(link_rise) && $past(en_low))
    else $error("single phy drove without read enable");

  multi_phy_arrangement_drive_a: assert property (
    (role_phy && $past(role_phy) && multi_phy_arrangement && $past(multi_phy_arrangement)
      && !cell_byte_oe_n && $past(link_rise)) |-> sel_r == UCO_SEL)
    else $error("multi phy drove while not selected");

  byte_order_a: assert property (
    advance |=> cell_byte_out == $past(stage_byte_r))
    else $error("launched byte differs from staged byte");

  reset_out_a: assert property (@(posedge sys_clk)
    $past(rst) |-> cell_byte_out == `UCO_BYTE_RST && !cell_start_out
      && cell_byte_oe_n == $past(role_phy))
    else $error("wrong output state during reset");

  unsel_fall_a: assert property (
    (link_rise && en_low && !en_prev_low_r && !sel_low) |=> sel_r == UCO_IDLE)
    else $error("selected without read select low");

  full_stop_a: assert property (
    (!role_phy && link_rise && full_low) |=> $stable(cell_byte_out) && !cell_start_out)
    else $error("write issued while far side full");

endmodule : uco_cell_out

// ### testbench/uco_far_model.sv
// far-side utopia party: cell clock, control pins, start-of-cell sampling
`timescale 1ns/1ns

module uco_far_model (
  input  wire logic en_req,
  input  wire logic full_req,
  input  wire logic sel_req,
  input  wire logic cell_byte_oe_n,
  input  wire logic cell_start_out,
  output logic      cell_out_clock,
  output logic      far_read_enable_n,
  output logic      far_full_n,
  output logic      read_select_n,
  output int        soc_cnt
);
  logic wire_soc;
  // a released line shows the inverse of its last value
  assign wire_soc = cell_byte_oe_n ? ~cell_start_out : cell_start_out;
  initial begin
    cell_out_clock = 1'b0;
    far_read_enable_n = 1'b1;
    far_full_n = 1'b1;
    read_select_n = 1'b1;
    soc_cnt = 0;
  end
  // 125 ns cell clock, under the 33 MHz ceiling
  always begin
    #63 cell_out_clock = 1'b1;
    #62 cell_out_clock = 1'b0;
  end
  // pins move 20 ns after the edge, and reach the port after it has seen the clock rise
  always @(posedge cell_out_clock) begin
    if (wire_soc && !cell_byte_oe_n) soc_cnt <= soc_cnt + 1;
    far_read_enable_n <= #20 en_req;
    far_full_n <= #20 full_req;
    read_select_n <= #20 sel_req;
  end
endmodule : uco_far_model

// ### testbench/utopia_cell_output_port_test.sv
// self-checking bench for the cell output port
`timescale 1ns/1ns

module utopia_cell_output_port_test;
  import uco_pkg::*;
  logic      sys_clk, rst, layer_role_strap, multi_phy_arrangement, in_valid, in_first;
  logic      clk_l, en_n, full_n, sel_n, in_ready, oe_n, soc, soe_n, en_req, full_req, sel_req;
  uco_byte_t in_byte, out_b, b;
  int        soc_cnt, error_cnt, cmp_count;

  uco_cell_out i_uco_cell_out (.sys_clk(sys_clk), .rst(rst),
    .layer_role_strap(layer_role_strap), .multi_phy_arrangement(multi_phy_arrangement),
    .cell_out_clock(clk_l), .far_read_enable_n(en_n), .far_full_n(full_n),
    .read_select_n(sel_n), .in_valid(in_valid), .in_byte(in_byte), .in_first(in_first),
    .in_ready(in_ready), .cell_byte_out(out_b), .cell_byte_oe_n(oe_n),
    .cell_start_out(soc), .cell_start_oe_n(soe_n));
  uco_far_model i_uco_far_model (.en_req(en_req), .full_req(full_req), .sel_req(sel_req),
    .cell_byte_oe_n(oe_n), .cell_start_out(soc), .cell_out_clock(clk_l),
    .far_read_enable_n(en_n), .far_full_n(full_n), .read_select_n(sel_n), .soc_cnt(soc_cnt));

  always #5 sys_clk = ~sys_clk;

  // expected {byte oe, start oe, start, byte}
  function automatic logic [10:0] exp_bus(input logic oe, input logic f, input uco_byte_t v);
    return {oe, oe, f, v};
  endfunction : exp_bus
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    for (int n = 0; in_ready !== 1'b1; n++) begin
      if (n > 200) begin
        chk(in_ready, 1'b1);
        test_done();
      end
      tick(1);
    end
  endtask : wait_rdy
  task automatic put(input uco_byte_t v, input logic f);
    wait_rdy();
    in_valid = 1'b1;
    in_byte = v;
    in_first = f;
    tick(1);
    in_valid = 1'b0;
  endtask : put
  // wait for the launch, then bus, marker and enables must match
  task automatic launched(input uco_byte_t v, input logic f);
    wait_rdy();
    chk({oe_n, soe_n, soc, out_b}, exp_bus(1'b0, f, v));
  endtask : launched
  task automatic do_reset(input logic strap, input logic multi);
    layer_role_strap = strap;
    multi_phy_arrangement = multi;
    rst = 1'b1;
    tick(6);
    chk({oe_n, soe_n, soc, out_b}, exp_bus(strap, 1'b0, 8'h00));
    rst = 1'b0;
    tick(2);
  endtask : do_reset

  initial begin
    {sys_clk, rst, layer_role_strap, multi_phy_arrangement, in_valid, in_first} = 6'h10;
    {en_req, full_req, sel_req} = 3'h7;
    in_byte = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'h4fb7));
    do_reset(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      b = (i == 1) ? 8'h80 : (i == 2) ? 8'h01 : 8'($urandom);
      put(b, i % 4 == 0);
      launched(b, i % 4 == 0);
    end
    full_req = 1'b0;
    tick(30);
    put(8'h5A, 1'b0);
    tick(80);
    chk(in_ready, 1'b0);
    full_req = 1'b1;
    launched(8'h5A, 1'b0);
    $display("atm role test done");
    for (int m = 0; m < 2; m++) begin
      do_reset(1'b1, m[0]);
      // single: enable held high; multi: enable falls with select high
      en_req = !m[0];
      b = 8'($urandom);
      put(b, 1'b1);
      tick(80);
      chk({in_ready, oe_n, soe_n}, 3'h3);
      en_req = 1'b1;
      tick(30);
      sel_req = 1'b0;
      en_req = 1'b0;
      launched(b, 1'b1);
      en_req = 1'b1;
      sel_req = 1'b1;
      tick(40);
      chk({oe_n, soe_n}, 2'h3);
      $display("phy role test done");
    end
    chk(11'(soc_cnt), 11'h004);
    test_done();
  end
endmodule : utopia_cell_output_port_test
